/* logic/uaux_pkg.sv */
// Purpose: Shared constants for the auxiliary-mode UART channel
// Assumes: MCLK at 40 MHz, byte-wide host bus, three address lines
// Notes: Register offsets are the three-bit channel addresses
package uaux_pkg;
	// ********************************************************
	// Register addresses
	// ********************************************************
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IEN = 3'h1;
	localparam logic [2:0] ADDR_ISTAT = 3'h2;
	localparam logic [2:0] ADDR_LCTL = 3'h3;
	localparam logic [2:0] ADDR_MCTL = 3'h4;
	localparam logic [2:0] ADDR_LSTAT = 3'h5;
	localparam logic [2:0] ADDR_MSTAT = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;
	// ********************************************************
	// Field positions and values
	// ********************************************************
	localparam int LC_DIV_BIT = 7;
	localparam logic [7:0] LC_ENH_KEY = 8'hBF;
	localparam int MC_IR_BIT = 6;
	localparam int MC_LOOP_BIT = 4;
	localparam int MC_OP2_BIT = 3;
	localparam int MC_OP1_BIT = 2;
	localparam int MC_RTS_BIT = 1;
	localparam int MC_DTR_BIT = 0;
	localparam int IE_SLEEP_BIT = 4;
	localparam logic [7:0] IEN_BASE_MASK = 8'h0F;
	localparam logic [7:0] ISTAT_NONE = 8'h01;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	localparam logic [7:0] RESET_LSTAT = 8'h60;
	// ********************************************************
	// Bit timing: 16 samples per bit, pulse of 3 of them
	// ********************************************************
	localparam int SAMPLES_PER_BIT = 16;
	localparam int IR_PULSE_SAMPLES = 3;
	localparam logic [3:0] SAMPLE_LAST = 4'hF;
	localparam logic [3:0] SAMPLE_MID = 4'h7;
	localparam logic [3:0] FRAME_BITS = 4'h9;
endpackage : uaux_pkg

/* logic/uaux_fifo2.sv */
// Purpose: Two-entry valid/ready buffer for received bytes
// Assumes: Single clock, asynchronous active-high reset
// Notes: Full when both entries hold data
module uaux_fifo2 #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic in_valid, // Writer has data
	output logic in_ready, // Room for data
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Data available
	input wire logic out_ready, // Reader takes data
	output logic [WIDTH-1:0] out_data // Head data
);
	logic [WIDTH-1:0] mem_q [2];
	logic [1:0] count_q;
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic push;
	logic pop;
	// Handshakes
	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_ptr_q];
	// Storage has no reset, only pointers and count do
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end
	// Pointers and occupancy
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= 2'h0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			if (push && !pop) begin
				count_q <= count_q + 2'h1;
			end else if (pop && !push) begin
				count_q <= count_q - 2'h1;
			end
		end
	end
	// Count never passes two
	a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
		count_q <= 2'h2) else $error("fifo count overflow");
endmodule : uaux_fifo2

/* logic/uaux_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Reset value given per instance
// Notes: First stage feeds only the second
module uaux_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic d, // Asynchronous input
	output logic q // Synchronised level
);
	logic meta_q;
	// Two stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : uaux_sync

/* logic/uaux_chan.sv */
// Purpose: One UART channel: register map, IR coding, loopback, sleep
// Assumes: Bus strobes asynchronous, synchronised before use
// Notes: Baud tick is one sample period per MCLK (divisor kept only)
module uaux_chan (
	input wire logic MCLK, // System clock
	input wire logic RST, // Async reset, active high
	input wire logic [2:0] ADDR, // Register address lines
	input wire logic [7:0] DATA_IN, // Host write data
	output logic [7:0] DATA_OUT, // Host read data
	output logic DATA_OE, // Read data drive enable
	input wire logic CHAN_SELECT_N, // Channel select, active low
	input wire logic WRITE_STROBE_N, // Write strobe, active low
	input wire logic READ_STROBE_N, // Read strobe, active low
	input wire logic FIFO_STATUS_SELECT_N, // Status read select
	input wire logic RX_PIN, // Serial receive input
	output logic TX_PIN, // Serial transmit output
	input wire logic CTS_N, // Clear to send
	input wire logic DSR_N, // Data set ready
	input wire logic CARRIER_DETECT_N, // Carrier detect
	input wire logic RING_INDICATE_N, // Ring indicate
	output logic RTS_N, // Request to send
	output logic DTR_N, // Terminal ready
	input wire logic ALL_CHAN_QUIET, // Other channels allow sleep
	output logic SLEEP_READY, // This channel allows sleep
	output logic OSC_RUN, // Oscillator enable
	output logic OSC_OUT_PIN // Oscillator output mirror
);
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SHIFT = 3'b010,
		TX_WAIT = 3'b100
	} uaux_tx_type;
	// ********************************************************
	// Synchronisers and strobes
	// ********************************************************
	logic rx_s, cts_s, dsr_s, cd_s, ri_s, wr_s, rd_s, sel_s, fs_s;
	logic wr_d1_q, rd_d1_q;
	uaux_sync #(.INIT(1'b1)) u_rx (.clk(MCLK), .rst(RST), .d(RX_PIN), .q(rx_s));
	uaux_sync #(.INIT(1'b1)) u_cts (.clk(MCLK), .rst(RST), .d(CTS_N), .q(cts_s));
	uaux_sync #(.INIT(1'b1)) u_dsr (.clk(MCLK), .rst(RST), .d(DSR_N), .q(dsr_s));
	uaux_sync #(.INIT(1'b1)) u_cd (.clk(MCLK), .rst(RST),
		.d(CARRIER_DETECT_N), .q(cd_s));
	uaux_sync #(.INIT(1'b1)) u_ri (.clk(MCLK), .rst(RST),
		.d(RING_INDICATE_N), .q(ri_s));
	uaux_sync #(.INIT(1'b1)) u_wr (.clk(MCLK), .rst(RST),
		.d(WRITE_STROBE_N), .q(wr_s));
	uaux_sync #(.INIT(1'b1)) u_rd (.clk(MCLK), .rst(RST),
		.d(READ_STROBE_N), .q(rd_s));
	uaux_sync #(.INIT(1'b1)) u_sel (.clk(MCLK), .rst(RST),
		.d(CHAN_SELECT_N), .q(sel_s));
	uaux_sync #(.INIT(1'b1)) u_fs (.clk(MCLK), .rst(RST),
		.d(FIFO_STATUS_SELECT_N), .q(fs_s));
	logic wr_ev, rd_ev, rd_act;
	// Strobe edge history
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wr_d1_q <= 1'b1;
			rd_d1_q <= 1'b1;
		end else begin
			wr_d1_q <= wr_s;
			rd_d1_q <= rd_s;
		end
	end
	assign wr_ev = wr_d1_q && !wr_s && !sel_s;
	assign rd_ev = rd_d1_q && !rd_s && !sel_s;
	assign rd_act = !rd_s && !sel_s;
	// ********************************************************
	// Registers
	// ********************************************************
	logic [7:0] ien_q, lctl_q, mctl_q, scr_q, dll_q, dlm_q, dld_q, efr_q;
	logic [7:0] xon1_q, xon2_q, xoff1_q, xoff2_q, fctl_q, thr_q;
	logic thr_full_q;
	logic div_sel, enh_sel, ir_on, loop_on;
	assign div_sel = lctl_q[uaux_pkg::LC_DIV_BIT]
		&& (lctl_q != uaux_pkg::LC_ENH_KEY);
	assign enh_sel = (lctl_q == uaux_pkg::LC_ENH_KEY);
	assign ir_on = mctl_q[uaux_pkg::MC_IR_BIT];
	assign loop_on = mctl_q[uaux_pkg::MC_LOOP_BIT];
	logic tx_take;
	// Host writes, decoded per map
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ien_q <= uaux_pkg::RESET_ZERO;
			lctl_q <= uaux_pkg::RESET_ZERO;
			mctl_q <= uaux_pkg::RESET_ZERO;
			scr_q <= uaux_pkg::RESET_ZERO;
			dll_q <= uaux_pkg::RESET_ZERO;
			dlm_q <= uaux_pkg::RESET_ZERO;
			dld_q <= uaux_pkg::RESET_ZERO;
			efr_q <= uaux_pkg::RESET_ZERO;
			xon1_q <= uaux_pkg::RESET_ZERO;
			xon2_q <= uaux_pkg::RESET_ZERO;
			xoff1_q <= uaux_pkg::RESET_ZERO;
			xoff2_q <= uaux_pkg::RESET_ZERO;
			fctl_q <= uaux_pkg::RESET_ZERO;
			thr_q <= uaux_pkg::RESET_ZERO;
			thr_full_q <= 1'b0;
		end else begin
			if (tx_take) begin
				thr_full_q <= 1'b0;
			end
			if (wr_ev) begin
				if (div_sel && ADDR == uaux_pkg::ADDR_DATA) begin
					dll_q <= DATA_IN;
				end else if (div_sel && ADDR == uaux_pkg::ADDR_IEN) begin
					dlm_q <= DATA_IN;
				end else if (div_sel && ADDR == uaux_pkg::ADDR_ISTAT) begin
					dld_q <= DATA_IN;
				end else if (enh_sel && ADDR == uaux_pkg::ADDR_ISTAT) begin
					efr_q <= DATA_IN;
				end else if (enh_sel && ADDR == uaux_pkg::ADDR_MCTL) begin
					xon1_q <= DATA_IN;
				end else if (enh_sel && ADDR == uaux_pkg::ADDR_LSTAT) begin
					xon2_q <= DATA_IN;
				end else if (enh_sel && ADDR == uaux_pkg::ADDR_MSTAT) begin
					xoff1_q <= DATA_IN;
				end else if (enh_sel && ADDR == uaux_pkg::ADDR_SCRATCH) begin
					xoff2_q <= DATA_IN;
				end else if (ADDR == uaux_pkg::ADDR_DATA) begin
					thr_q <= DATA_IN;
					thr_full_q <= 1'b1;
				end else if (ADDR == uaux_pkg::ADDR_IEN) begin
					ien_q <= DATA_IN;
				end else if (ADDR == uaux_pkg::ADDR_ISTAT) begin
					fctl_q <= DATA_IN;
				end else if (ADDR == uaux_pkg::ADDR_LCTL) begin
					lctl_q <= DATA_IN;
				end else if (ADDR == uaux_pkg::ADDR_MCTL) begin
					mctl_q <= DATA_IN;
				end else if (ADDR == uaux_pkg::ADDR_SCRATCH) begin
					scr_q <= DATA_IN;
				end
			end
		end
	end
	// ********************************************************
	// Sample timing and transmitter
	// ********************************************************
	logic [3:0] smp_q;
	logic bit_end;
	// Free-running sample counter, one bit per wrap
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			smp_q <= 4'h0;
		end else begin
			smp_q <= smp_q + 4'h1;
		end
	end
	assign bit_end = (smp_q == uaux_pkg::SAMPLE_LAST);
	uaux_tx_type tx_st_q;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_cnt_q;
	logic tx_ser;
	assign tx_take = (tx_st_q == TX_WAIT) && bit_end;
	// Transmit shifter: start, 8 data, stop
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= 10'h3FF;
			tx_cnt_q <= 4'h0;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					if (thr_full_q) begin
						tx_st_q <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					if (bit_end) begin
						tx_sh_q <= {1'b1, thr_q, 1'b0};
						tx_cnt_q <= 4'h0;
						tx_st_q <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (bit_end) begin
						tx_sh_q <= {1'b1, tx_sh_q[9:1]};
						tx_cnt_q <= tx_cnt_q + 4'h1;
						if (tx_cnt_q == uaux_pkg::FRAME_BITS) begin
							tx_st_q <= TX_IDLE;
						end
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end
	assign tx_ser = tx_sh_q[0];
	logic ir_pulse;
	// pulse for 3 of 16 samples per zero bit
	assign ir_pulse = !tx_ser && (int'(smp_q) < uaux_pkg::IR_PULSE_SAMPLES);
	// Pin drive from a flop; loopback marks the line
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			TX_PIN <= 1'b1;
		end else if (loop_on) begin
			TX_PIN <= 1'b1;
		end else if (ir_on) begin
			TX_PIN <= ir_pulse;
		end else begin
			TX_PIN <= tx_ser;
		end
	end
	// ********************************************************
	// Receiver with IR decoder and loopback path
	// ********************************************************
	logic rx_bit, rx_line, rx_prev_q, ir_rise;
	logic [3:0] ir_hold_q;
	// each pulse start stretched to one bit of zero
	// Keyed to the rise, so a pulse across a bit end counts once
	assign ir_rise = rx_s && !rx_prev_q;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ir_hold_q <= 4'h0;
		end else if (ir_rise) begin
			ir_hold_q <= uaux_pkg::SAMPLE_LAST;
		end else if (ir_hold_q != 4'h0) begin
			ir_hold_q <= ir_hold_q - 4'h1;
		end
	end
	// IR line idles low: no pulse means one
	assign rx_bit = ir_on ? !(ir_rise || ir_hold_q != 4'h0) : rx_s;
	assign rx_line = loop_on ? tx_ser : rx_bit;
	logic [8:0] rx_sh_q;
	logic [3:0] rx_cnt_q;
	logic rx_busy_q, rx_push, rx_rdy, fifo_in_rdy, rx_pop;
	logic [7:0] rx_head;
	// Receive shifter sampled at bit end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rx_busy_q <= 1'b0;
			rx_sh_q <= 9'h000;
			rx_cnt_q <= 4'h0;
		end else if (bit_end) begin
			if (!rx_busy_q) begin
				if (!rx_line) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q <= 4'h0;
				end
			end else begin
				rx_sh_q <= {rx_line, rx_sh_q[8:1]};
				rx_cnt_q <= rx_cnt_q + 4'h1;
				if (rx_cnt_q == 4'h8) begin
					rx_busy_q <= 1'b0;
				end
			end
		end
	end
	// Byte lost if both entries are full or its stop bit reads low
	assign rx_push = bit_end && rx_busy_q && (rx_cnt_q == 4'h8) && rx_line;
	uaux_fifo2 #(.WIDTH(8)) u_rxbuf (.clk(MCLK), .rst(RST),
		.in_valid(rx_push), .in_ready(fifo_in_rdy),
		.in_data(rx_sh_q[8:1]), .out_valid(rx_rdy), .out_ready(rx_pop),
		.out_data(rx_head));
	// ********************************************************
	// Modem lines and status
	// ********************************************************
	logic [3:0] mdm_in, mdm_prev_q, delta_q;
	assign mdm_in = loop_on
		? {mctl_q[uaux_pkg::MC_OP2_BIT], mctl_q[uaux_pkg::MC_OP1_BIT],
			mctl_q[uaux_pkg::MC_DTR_BIT], mctl_q[uaux_pkg::MC_RTS_BIT]}
		: {!cd_s, !ri_s, !dsr_s, !cts_s};
	logic msr_rd;
	assign msr_rd = rd_ev && fs_s && !enh_sel
		&& ADDR == uaux_pkg::ADDR_MSTAT;
	// read clears deltas; a new change wins
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			mdm_prev_q <= 4'h0;
			delta_q <= 4'h0;
		end else begin
			mdm_prev_q <= mdm_in;
			delta_q <= (msr_rd ? 4'h0 : delta_q) | (mdm_in ^ mdm_prev_q);
		end
	end
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			RTS_N <= 1'b1;
			DTR_N <= 1'b1;
		end else begin
			RTS_N <= loop_on || !mctl_q[uaux_pkg::MC_RTS_BIT];
			DTR_N <= loop_on || !mctl_q[uaux_pkg::MC_DTR_BIT];
		end
	end
	// ********************************************************
	// Interrupt status and sleep
	// ********************************************************
	logic [7:0] istat;
	logic thr_empty;
	assign thr_empty = !thr_full_q;
	// Priority: line is idle-only here, then rx, tx, modem
	always_comb begin
		istat = uaux_pkg::ISTAT_NONE;
		if (ien_q[0] && rx_rdy) begin
			istat = 8'h04;
		end else if (ien_q[1] && thr_empty && tx_st_q == TX_IDLE) begin
			istat = 8'h02;
		end else if (ien_q[3] && delta_q != 4'h0) begin
			istat = 8'h00;
		end
	end
	logic idle_high, wake_rx;
	assign idle_high = rx_s && !ir_on;
	assign SLEEP_READY = istat[0] && ien_q[uaux_pkg::IE_SLEEP_BIT]
		&& delta_q == 4'h0 && idle_high && !thr_full_q
		&& tx_st_q == TX_IDLE && !rx_busy_q;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= rx_s;
		end
	end
	assign wake_rx = rx_prev_q && !rx_s;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			OSC_RUN <= 1'b1;
		end else if (wake_rx || wr_ev || delta_q != 4'h0) begin
			OSC_RUN <= 1'b1;
		end else begin
			OSC_RUN <= !(SLEEP_READY && ALL_CHAN_QUIET);
		end
	end
	// output pin shows clock only while running
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			OSC_OUT_PIN <= 1'b0;
		end else begin
			OSC_OUT_PIN <= OSC_RUN && !OSC_OUT_PIN;
		end
	end
	// ********************************************************
	// Read mux
	// ********************************************************
	logic [7:0] rd_d, lstat;
	assign lstat = {1'b0, thr_empty && tx_st_q == TX_IDLE, thr_empty,
		4'h0, rx_rdy};
	assign rx_pop = rd_ev && fs_s && !div_sel && !enh_sel
		&& ADDR == uaux_pkg::ADDR_DATA;
	always_comb begin
		rd_d = uaux_pkg::RESET_ZERO;
		if (!fs_s) begin
			rd_d = {6'h00, !fifo_in_rdy, rx_rdy};
		end else if (div_sel && ADDR == uaux_pkg::ADDR_DATA) begin
			rd_d = dll_q;
		end else if (div_sel && ADDR == uaux_pkg::ADDR_IEN) begin
			rd_d = dlm_q;
		end else if (div_sel && ADDR == uaux_pkg::ADDR_ISTAT) begin
			rd_d = dld_q;
		end else if (enh_sel && ADDR == uaux_pkg::ADDR_ISTAT) begin
			rd_d = efr_q;
		end else if (enh_sel && ADDR == uaux_pkg::ADDR_MCTL) begin
			rd_d = xon1_q;
		end else if (enh_sel && ADDR == uaux_pkg::ADDR_LSTAT) begin
			rd_d = xon2_q;
		end else if (enh_sel && ADDR == uaux_pkg::ADDR_MSTAT) begin
			rd_d = xoff1_q;
		end else if (enh_sel && ADDR == uaux_pkg::ADDR_SCRATCH) begin
			rd_d = xoff2_q;
		end else if (ADDR == uaux_pkg::ADDR_DATA) begin
			rd_d = rx_head;
		end else if (ADDR == uaux_pkg::ADDR_IEN) begin
			rd_d = ien_q;
		end else if (ADDR == uaux_pkg::ADDR_ISTAT) begin
			rd_d = istat;
		end else if (ADDR == uaux_pkg::ADDR_LCTL) begin
			rd_d = lctl_q;
		end else if (ADDR == uaux_pkg::ADDR_MCTL) begin
			rd_d = mctl_q;
		end else if (ADDR == uaux_pkg::ADDR_LSTAT) begin
			rd_d = lstat;
		end else if (ADDR == uaux_pkg::ADDR_MSTAT) begin
			rd_d = {mdm_in, delta_q};
		end else begin
			rd_d = scr_q;
		end
	end
	// Data captured once, at the falling edge of the read strobe
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			DATA_OUT <= uaux_pkg::RESET_ZERO;
			DATA_OE <= 1'b0;
		end else begin
			DATA_OE <= rd_act;
			if (rd_ev) begin
				DATA_OUT <= rd_d;
			end
		end
	end
	// ********************************************************
	// Checks
	// ********************************************************
	a_loop_mark: assert property (@(posedge MCLK) disable iff (RST)
		$past(loop_on) |-> TX_PIN && RTS_N && DTR_N)
		else $error("loopback pins not inactive");
	a_ir_idle: assert property (@(posedge MCLK) disable iff (RST)
		$past(ir_on && !loop_on && tx_ser) |-> !TX_PIN)
		else $error("ir idle not low");
	a_msr_clear: assert property (@(posedge MCLK) disable iff (RST)
		msr_rd && mdm_in == mdm_prev_q |=> delta_q == 4'h0)
		else $error("modem read did not clear deltas");
	a_wake_write: assert property (@(posedge MCLK) disable iff (RST)
		wr_ev |=> OSC_RUN) else $error("write did not wake");
	a_sleep_hold: assert property (@(posedge MCLK) disable iff (RST)
		!ien_q[uaux_pkg::IE_SLEEP_BIT] |=> OSC_RUN)
		else $error("asleep with sleep disabled");
endmodule : uaux_chan

/* test/uaux_line_model.sv */
// Purpose: Far-side serial sender feeding the channel receive pin
// Assumes: 16 clocks per bit, 8N1, LSB first
// Notes: Line rests at mark, or dark while sending infrared
module uaux_line_model (
	input wire logic clk, // Clock
	input wire logic start, // Send one byte
	input wire logic [7:0] data, // Byte to send
	input wire logic ir, // Send infrared pulses
	output logic rx_pin // Line into the channel
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] frame;
	int n;
	initial rx_pin = 1'b1;
	// One frame per start pulse, back to mark (dark in infrared) after the stop bit
	always @(posedge clk) begin
		if (start) begin
			frame = {1'b1, data, 1'b0};
			for (n = 0; n < 160; n++) begin
				// infrared zero is a 3/16 pulse
				rx_pin <= ir ? (!frame[n/16] && n % 16 < 3) : frame[n/16];
				@(posedge clk);
			end
		end else begin
			// Idle: mark, or dark in infrared
			rx_pin <= !ir;
		end
	end
endmodule : uaux_line_model

/* test/tb.sv */
// Purpose: Self-checking bench for one auxiliary-mode channel
// Assumes: Host strobes held 5 clocks, spaced 5 clocks
// Notes: Table rows first, then buffer, loopback, infrared and sleep
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic wr; logic [2:0] a; logic [7:0] d;} uaux_row_type;
	logic mclk = 0, rst = 1, cs_n = 1, wr_n = 1, rd_n = 1, fs_n = 1;
	logic [2:0] addr = 3'h0;
	logic [7:0] din = 8'h00, dout, q, sb = 8'h00;
	logic cts_n = 1, dsr_n = 1, cd_n = 1, ri_n = 1, quiet = 1, go = 0;
	logic rx, tx, oe, rts_n, dtr_n, sready, osc_run, osc_out, loop_on = 0;
	logic tx_bad = 0, ir_on = 0, ir_rx = 0, oe_hi = 0;
	int num_errors = 0, n_checks = 0, cyc = 0, ir_cnt = 0, i;
	// Writes carry d, reads expect d
	uaux_row_type rows[] = '{'{0,3'h3,8'h00}, '{0,3'h4,8'h00},
		'{0,3'h1,8'h00}, '{0,3'h2,8'h01}, '{0,3'h5,8'h60},
		'{1,3'h7,8'hA5}, '{0,3'h7,8'hA5}, '{1,3'h3,8'hBF},
		'{1,3'h2,8'h10}, '{1,3'h4,8'h11}, '{1,3'h5,8'h22},
		'{1,3'h6,8'h33}, '{1,3'h7,8'h44}, '{0,3'h2,8'h10},
		'{0,3'h4,8'h11}, '{0,3'h5,8'h22}, '{0,3'h6,8'h33},
		'{0,3'h7,8'h44}, '{1,3'h3,8'h80}, '{1,3'h0,8'h12},
		'{1,3'h1,8'h34}, '{1,3'h2,8'h05}, '{0,3'h0,8'h12},
		'{0,3'h1,8'h34}, '{0,3'h2,8'h05}, '{1,3'h3,8'h03},
		'{0,3'h7,8'hA5}, '{0,3'h1,8'h00}, '{0,3'h4,8'h00},
		'{1,3'h5,8'hFF}, '{0,3'h5,8'h60}};
	uaux_chan dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .DATA_IN(din),
		.DATA_OUT(dout), .DATA_OE(oe), .CHAN_SELECT_N(cs_n),
		.WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n),
		.FIFO_STATUS_SELECT_N(fs_n), .RX_PIN(rx), .TX_PIN(tx),
		.CTS_N(cts_n), .DSR_N(dsr_n), .CARRIER_DETECT_N(cd_n),
		.RING_INDICATE_N(ri_n), .RTS_N(rts_n), .DTR_N(dtr_n),
		.ALL_CHAN_QUIET(quiet), .SLEEP_READY(sready), .OSC_RUN(osc_run),
		.OSC_OUT_PIN(osc_out));
	uaux_line_model line (.clk(mclk), .start(go), .data(sb), .ir(ir_rx),
		.rx_pin(rx));
	// ****************************************
	// Clock, watchdog and pin monitors
	// ****************************************
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (loop_on && tx !== 1'b1) tx_bad = 1;
		if (ir_on && tx === 1'b1) ir_cnt++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One strobe held 5 clocks, then 5 clocks idle
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [7:0] d, input logic sel_n);
		@(posedge mclk);
		#2;
		addr = a;
		din = d;
		cs_n = sel_n;
		wr_n = ~w;
		rd_n = w;
		repeat (5) @(posedge mclk);
		q = dout;
		oe_hi = oe;
		#2;
		{cs_n, wr_n, rd_n} = 3'h7;
		repeat (5) @(posedge mclk);
		#2;
	endtask : bus
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		bus(0, a, 8'h00, 0);
		check(q, e);
		check({7'h0, oe_hi}, 8'h01);
		check({7'h0, oe}, 8'h00);
	endtask : rd
	task automatic send(input logic [7:0] b);
		sb = b;
		go = 1;
		@(posedge mclk);
		#2;
		go = 0;
		repeat (170) @(posedge mclk);
		#2;
	endtask : send
	task automatic wait_osc(input logic v);
		for (i = 0; i < 400 && osc_run !== v; i++) @(posedge mclk) #2;
		#2;
		check({7'h0, osc_run}, {7'h0, v});
	endtask : wait_osc
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge mclk);
		#2;
		rst = 0;
		foreach (rows[k]) begin
			if (rows[k].wr) bus(1, rows[k].a, rows[k].d, 0);
			else rd(rows[k].a, rows[k].d);
		end
		bus(1, 3'h7, 8'h5B, 1);
		rd(3'h7, 8'hA5);
		// Third byte finds the buffer full and is dropped
		send(8'hC3);
		send(8'h3C);
		send(8'h55);
		fs_n = 0;
		rd(3'h6, 8'h03);
		fs_n = 1;
		rd(3'h0, 8'hC3);
		rd(3'h0, 8'h3C);
		fs_n = 0;
		rd(3'h2, 8'h00);
		fs_n = 1;
		bus(1, 3'h4, 8'h03, 0);
		check({6'h0, rts_n, dtr_n}, 8'h00);
		bus(1, 3'h4, 8'h13, 0);
		loop_on = 1;
		check({6'h0, rts_n, dtr_n}, 8'h03);
		bus(1, 3'h0, 8'h5A, 0);
		repeat (200) @(posedge mclk);
		rd(3'h0, 8'h5A);
		rd(3'h6, 8'h33);
		cts_n = 0;
		repeat (8) @(posedge mclk);
		rd(3'h6, 8'h30);
		loop_on = 0;
		check({7'h0, tx_bad}, 8'h00);
		cts_n = 1;
		bus(1, 3'h4, 8'h40, 0);
		check({7'h0, tx}, 8'h00);
		ir_on = 1;
		ir_rx = 1;
		bus(1, 3'h0, 8'h00, 0);
		repeat (200) @(posedge mclk);
		ir_on = 0;
		check(ir_cnt[7:0], 8'h1B);
		send(8'hA6);
		rd(3'h0, 8'hA6);
		// Dark-to-mark step reads as one pulse, then ones
		ir_rx = 0;
		repeat (200) @(posedge mclk);
		#2;
		rd(3'h0, 8'hFF);
		bus(1, 3'h4, 8'h00, 0);
		bus(0, 3'h6, 8'h00, 0);
		bus(1, 3'h1, 8'h10, 0);
		wait_osc(0);
		check({7'h0, sready}, 8'h01);
		sb = {7'h0, osc_out};
		repeat (20) @(posedge mclk);
		check({7'h0, osc_out}, sb);
		cts_n = 0;
		wait_osc(1);
		check({7'h0, sready}, 8'h00);
		sb = {7'h0, osc_out};
		@(posedge mclk);
		#2;
		check({7'h0, ~osc_out}, sb);
		rd(3'h6, 8'h11);
		wait_osc(0);
		bus(1, 3'h0, 8'h77, 0);
		check({7'h0, osc_run}, 8'h01);
		wait_osc(0);
		go = 1;
		@(posedge mclk);
		#2;
		go = 0;
		repeat (20) @(posedge mclk);
		check({7'h0, osc_run}, 8'h01);
		repeat (200) @(posedge mclk);
		wait_osc(0);
		quiet = 0;
		wait_osc(1);
		quiet = 1;
		wait_osc(0);
		bus(1, 3'h1, 8'h00, 0);
		repeat (100) @(posedge mclk);
		check({7'h0, osc_run}, 8'h01);
		finish_test();
	end
endmodule : tb
